// ==== ctle_pkg.sv ====
// Purpose: Shared constants and types for the capacitive touch low-power and event block.
// Assumes: 40 MHz clock, byte-wide registers on a plain strobe port.
// Notes:   Offsets of all registers are local choices.
package ctle_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned US_PER_MS = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

    // Register offsets.
    localparam logic [3:0] OFS_SCAN_INTERVAL = 4'h0;
    localparam logic [3:0] OFS_ELECTRODE_SEL = 4'h1;
    localparam logic [3:0] OFS_LP_THRESHOLD  = 4'h2;
    localparam logic [3:0] OFS_RESOLUTION    = 4'h3;
    localparam logic [3:0] OFS_EVENT_ENABLES = 4'h4;
    localparam logic [3:0] OFS_SYS_CONFIG    = 4'h5;
    localparam logic [3:0] OFS_REPEAT_PERIOD = 4'h6;
    localparam logic [3:0] OFS_REPEAT_DELAY  = 4'h7;
    localparam logic [3:0] OFS_CONTROL_TYPE  = 4'h8;
    localparam logic [3:0] OFS_IRQ_STATUS    = 4'h9;
    localparam logic [3:0] OFS_IRQ_MASK      = 4'ha;

    // Field positions.
    localparam int unsigned BIT_FIRST_TOUCH = 0;
    localparam int unsigned BIT_MOVEMENT    = 1;
    localparam int unsigned BIT_HOLD        = 2;
    localparam int unsigned BIT_REPEAT      = 3;
    localparam int unsigned BIT_RELEASE     = 4;
    localparam int unsigned BIT_LP_ENABLE   = 2;
    localparam int unsigned NUM_EVENTS      = 5;

    // Reset values and the valid resolution range.
    localparam logic [3:0] RST_SCAN_CODE  = 4'h0;
    localparam logic [6:0] RST_THRESHOLD  = 7'h10;
    localparam logic [3:0] RST_RESOLUTION = 4'h8;
    localparam logic [3:0] RES_MIN        = 4'h8;
    localparam logic [3:0] RES_MAX        = 4'hb;
    localparam logic [7:0] RST_REPEAT     = 8'h00;

    typedef enum logic [1:0] {CT_KEYPAD, CT_ROTARY, CT_SLIDER, CT_NONE} ctle_ctrl_t;

    // Scan period table in milliseconds, indexed by the interval code.
    typedef logic [9:0] ctle_ms_t;
    localparam ctle_ms_t SCAN_MS [16] = '{
        10'd1,   10'd5,   10'd10,  10'd15,  10'd20,  10'd30,  10'd40,  10'd50,
        10'd75,  10'd100, 10'd125, 10'd150, 10'd200, 10'd300, 10'd400, 10'd500};

    // Sensing results delivered each measurement.
    typedef struct packed {
        logic       meas_done;
        logic [3:0] touched;
        logic [3:0] position;
    } ctle_sense_t;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ctle_req_t;

endpackage : ctle_pkg

// ==== ctle_event_cfg.sv ====
// Purpose: Low-power scan configuration and capacitive event generation.
// Assumes: Sense inputs are on clk; host port is a plain strobe bus.
// Notes:   Resolution changes only take effect on the next reset.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

// How it works
// (RULE1) The 4-bit scan code picks a fixed interval from 1 ms at code 0 up to 500 ms at code 15.
// (RULE2) Codes 4, 8, 12 and 13 give 20, 75, 200 and 300 ms.
// (RULE3) Software writes only listed codes into the scan interval field.
// (RULE4) Bits 1 to 0 pick the electrode scanned in shutdown while low-power enable is set.
// (RULE5) Bits 6 to 0 hold the threshold for the low-power electrode.
// (RULE6) Bits 3 to 0 set resolution, 8 to 11 valid and the rest reserved.
// (RULE7) A new resolution is used only after a reset.
// (RULE8) Event enable bits are interpreted per the configured control type.
// (RULE9) Enable bit 4 flags an event when every electrode is released.
// (RULE10) Enable bit 3 flags events at the repeat period while one electrode stays touched.
// (RULE11) Enable bit 2 flags one hold event after the repeat delay.
// (RULE12) Enable bit 1 flags an event when the rotary or slider position changes.
// (RULE13) Enable bit 0 flags an event on the first touch after all were released.
// (RULE14) While low-power enable is set no electrode is scanned in run mode, and it resets to 0.
// (RULE15) A repeat period of 1 to 255 repeats every that many measurements, 0 disables it.
// (RULE16) The repeat delay of 0 to 255 measurements must pass before repeats begin.
// (RULE17) Disabled conditions leave the event flag alone, and a set flag holds until acknowledged.
module ctle_event_cfg
    import ctle_pkg::*;
(
    input  wire logic        clk,          // 40 MHz clock.
    input  wire logic        rst_n,        // Synchronous reset, active low.
    input  wire logic        in_shutdown,  // Device is in shutdown mode.
    input  wire ctle_sense_t sense,        // Per-measurement touch results.
    input  wire ctle_req_t   req,          // Register access request.
    output logic       [7:0] rdata,        // Read data, one cycle after the read strobe.
    output logic             scan_run_en,  // Run-mode scanning allowed.
    output logic             lp_scan_en,   // Low-power single-electrode scanning active.
    output logic       [1:0] lp_electrode, // Electrode scanned in shutdown.
    output logic       [6:0] lp_threshold, // Threshold for the low-power electrode.
    output logic             lp_tick,      // One-cycle pulse at each low-power scan.
    output logic       [3:0] active_res,   // Resolution in use by sampling.
    output logic             cap_event,    // Sticky capacitive event flag.
    output logic             irq           // Level interrupt.
);

    // Register state. The hold and repeat counters are eight bits to match the byte-wide
    // delay and period settings; the low-power counter is sized for the longest interval.
    logic [3:0]            scan_code_q;
    logic [1:0]            lp_el_q;
    logic [6:0]            lp_thr_q;
    logic [3:0]            res_wr_q;
    logic [3:0]            res_act_q;
    logic [4:0]            ev_en_q;
    logic                  lp_en_q;
    logic [7:0]            rep_per_q;
    logic [7:0]            rep_dly_q;
    ctle_ctrl_t            ctrl_q;
    logic [NUM_EVENTS-1:0] irq_st_q;
    logic [NUM_EVENTS-1:0] irq_mask_q;
    logic [7:0]            rdata_q;
    logic                  cap_ev_q;
    logic [3:0]            touched_q;
    logic [3:0]            pos_q;
    logic [7:0]            hold_cnt_q;
    logic [7:0]            rep_cnt_q;
    logic                  hold_done_q;
    logic [27:0]           lp_cnt_q;

    // Address decode as named strobes. Writes to unmapped offsets match none of these and
    // are dropped, and reads of them fall through the read mux as zero, so software probing
    // an empty offset can never disturb the configuration.
    wire wr_scan  = req.wr && (req.addr == OFS_SCAN_INTERVAL);
    wire wr_el    = req.wr && (req.addr == OFS_ELECTRODE_SEL);
    wire wr_thr   = req.wr && (req.addr == OFS_LP_THRESHOLD);
    wire wr_res   = req.wr && (req.addr == OFS_RESOLUTION);
    wire wr_ev    = req.wr && (req.addr == OFS_EVENT_ENABLES);
    wire wr_sys   = req.wr && (req.addr == OFS_SYS_CONFIG);
    wire wr_per   = req.wr && (req.addr == OFS_REPEAT_PERIOD);
    wire wr_dly   = req.wr && (req.addr == OFS_REPEAT_DELAY);
    wire wr_ctl   = req.wr && (req.addr == OFS_CONTROL_TYPE);
    wire wr_mask  = req.wr && (req.addr == OFS_IRQ_MASK);
    wire rd_st    = req.rd && (req.addr == OFS_IRQ_STATUS);
    wire rd_ev    = req.rd && (req.addr == OFS_EVENT_ENABLES);

    // Reserved resolution codes are refused so sampling never sees them; a refused write
    // leaves the previously written value in place.
    wire res_ok   = (req.wdata[3:0] >= RES_MIN) && (req.wdata[3:0] <= RES_MAX); // RULE6

    // Low-power settings. The enable is cleared by every reset, so a device that resets
    // inside shutdown comes back scanning in run mode rather than sitting on one electrode
    // with the run scan blocked.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scan_code_q <= RST_SCAN_CODE;
            lp_el_q     <= '0;
            lp_thr_q    <= RST_THRESHOLD;
            lp_en_q     <= 1'b0; // RULE14
        end
        else
        begin
            if (wr_scan) scan_code_q <= req.wdata[3:0]; // RULE1
            if (wr_el)   lp_el_q     <= req.wdata[1:0]; // RULE4
            if (wr_thr)  lp_thr_q    <= req.wdata[6:0]; // RULE5
            if (wr_sys)  lp_en_q     <= req.wdata[BIT_LP_ENABLE]; // RULE14
        end
    end

    // Event settings. Enables, repeat timing and control type are plain storage; how a bit
    // is read depends on the control type, which the condition logic below applies.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ev_en_q    <= '0;
            rep_per_q  <= RST_REPEAT;
            rep_dly_q  <= RST_REPEAT;
            ctrl_q     <= CT_KEYPAD;
            irq_mask_q <= '0;
        end
        else
        begin
            if (wr_ev)   ev_en_q    <= req.wdata[NUM_EVENTS-1:0];
            if (wr_per)  rep_per_q  <= req.wdata; // RULE15
            if (wr_dly)  rep_dly_q  <= req.wdata; // RULE16
            if (wr_ctl)  ctrl_q     <= ctle_ctrl_t'(req.wdata[1:0]); // RULE8
            if (wr_mask) irq_mask_q <= req.wdata[NUM_EVENTS-1:0];
        end
    end

    // The written resolution survives reset; the active copy loads only at reset, so
    // sampling never sees a resolution change in mid-measurement. The written copy has no
    // reset of its own and is unknown until software first writes it: software must write a
    // valid code and then reset before the value in use can be trusted.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            res_act_q <= res_wr_q; // RULE7
        else if (wr_res && res_ok)
            res_wr_q <= req.wdata[3:0];
    end

    // Low-power scan interval counter, reloaded from the period table. It is held at zero
    // outside low-power shutdown, so the first scan starts at once on entry. A new code takes
    // effect at once in the running interval; a code that shortens the interval below the
    // current count wraps at the next cycle. The 28-bit count covers the 500 ms maximum.
    wire [27:0] lp_reload = 28'(SCAN_MS[scan_code_q]) * 28'(CYC_PER_MS); // RULE1 RULE2
    wire        lp_active = lp_en_q && in_shutdown; // RULE4
    always_ff @(posedge clk)
    begin
        if (!rst_n || !lp_active)
            lp_cnt_q <= '0;
        else if (lp_cnt_q >= lp_reload - 28'd1)
            lp_cnt_q <= '0;
        else
            lp_cnt_q <= lp_cnt_q + 28'd1;
    end

    // Measurement-level conditions, all qualified by the measurement strobe. Touch and
    // release look at the whole control; movement only means something on a rotary or
    // slider, where the position field is valid, so a keypad never reports it.
    wire any_now   = |sense.touched;
    wire any_prev  = |touched_q;
    wire m         = sense.meas_done;
    wire positional = (ctrl_q == CT_ROTARY) || (ctrl_q == CT_SLIDER); // RULE8
    wire same_key  = any_now && (sense.touched == touched_q);
    wire c_touch   = m && any_now && !any_prev; // RULE13
    wire c_release = m && !any_now && any_prev; // RULE9
    wire c_move    = m && positional && any_now && any_prev
                     && (sense.position != pos_q); // RULE12 RULE8

    // Hold and repeat timing. Both demand the very same touched set, so sliding a finger
    // onto a neighbour restarts the timing; a repeat period of zero keeps repeats off.
    wire hold_hit  = m && same_key && !hold_done_q && (hold_cnt_q >= rep_dly_q); // RULE16
    wire c_hold    = hold_hit && (ctrl_q == CT_KEYPAD || positional); // RULE11
    wire c_repeat  = m && same_key && hold_done_q && (rep_per_q != 8'h00)
                     && (rep_cnt_q + 8'd1 >= rep_per_q); // RULE10 RULE15

    // Conditions laid out at the bit positions of the enable register; each one only counts
    // when its enable bit is set, so a disabled condition leaves every flag untouched.
    logic [NUM_EVENTS-1:0] cond;
    assign cond[BIT_FIRST_TOUCH] = c_touch;   // RULE13
    assign cond[BIT_MOVEMENT]    = c_move;    // RULE12
    assign cond[BIT_HOLD]        = c_hold;    // RULE11
    assign cond[BIT_REPEAT]      = c_repeat;  // RULE10
    assign cond[BIT_RELEASE]     = c_release; // RULE9
    wire [NUM_EVENTS-1:0] hit  = cond & ev_en_q; // RULE17

    // Touch history, updated once per measurement. The previous set and position are what
    // touch, release and movement compare against.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            touched_q <= '0;
            pos_q     <= '0;
        end
        else if (m)
        begin
            touched_q <= sense.touched;
            pos_q     <= sense.position;
        end
    end

    // Hold counter: counts measurements with an unchanged touched set and saturates, so a
    // long press can never wrap round and fire a second hold event.
    wire restart = m && !same_key;
    always_ff @(posedge clk)
    begin
        if (!rst_n || restart)
        begin
            hold_cnt_q  <= '0;
            hold_done_q <= 1'b0;
        end
        else if (m && !hold_done_q)
        begin
            hold_done_q <= hold_hit; // RULE11
            if (hold_cnt_q != 8'hff)
                hold_cnt_q <= hold_cnt_q + 8'd1; // RULE16
        end
    end

    // Repeat counter: runs only after the hold point and restarts at every repeat event,
    // so the spacing between repeats is exactly the programmed period.
    always_ff @(posedge clk)
    begin
        if (!rst_n || restart)
            rep_cnt_q <= '0;
        else if (m && hold_done_q)
            rep_cnt_q <= c_repeat ? 8'h00 : rep_cnt_q + 8'd1; // RULE15
    end

    // Sticky flag: set wins over the acknowledge made by reading the enables register.
    // A read landing in the same cycle as a new event must not swallow that event; the
    // flag then stays up and the next read clears it.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cap_ev_q <= 1'b0;
        else if (|hit)
            cap_ev_q <= 1'b1; // RULE9 RULE10 RULE11 RULE12 RULE13
        else if (rd_ev)
            cap_ev_q <= 1'b0; // RULE17
    end

    // One sticky status bit per event kind, cleared by reading the status register. A new
    // hit in the same cycle as the read wins, so no event is lost to a badly timed read;
    // the bits are set independently, but one status read clears every kind not hit in that cycle.
    generate
        for (genvar ev = 0; ev < NUM_EVENTS; ev++)
        begin : g_status
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    irq_st_q[ev] <= 1'b0;
                else if (hit[ev])
                    irq_st_q[ev] <= 1'b1;
                else if (rd_st)
                    irq_st_q[ev] <= 1'b0;
            end
        end
    endgenerate

    // Read mux; unmapped offsets and reserved bits read as zero. The resolution offset
    // returns the written value, which may differ from the one in use until the next reset.
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        case (req.addr)
            OFS_SCAN_INTERVAL: rd_mux = {4'h0, scan_code_q};
            OFS_ELECTRODE_SEL: rd_mux = {6'h00, lp_el_q};
            OFS_LP_THRESHOLD:  rd_mux = {1'b0, lp_thr_q};
            OFS_RESOLUTION:    rd_mux = {4'h0, res_wr_q};
            OFS_EVENT_ENABLES: rd_mux = {cap_ev_q, 2'b00, ev_en_q};
            OFS_SYS_CONFIG:    rd_mux = {5'h00, lp_en_q, 2'b00};
            OFS_REPEAT_PERIOD: rd_mux = rep_per_q;
            OFS_REPEAT_DELAY:  rd_mux = rep_dly_q;
            OFS_CONTROL_TYPE:  rd_mux = {6'h00, ctrl_q};
            OFS_IRQ_STATUS:    rd_mux = {3'b000, irq_st_q};
            OFS_IRQ_MASK:      rd_mux = {3'b000, irq_mask_q};
            default:           rd_mux = 8'h00;
        endcase
    end

    // Read data stand for exactly the cycle after the read strobe and are zero otherwise,
    // so a stale value can never be mistaken for an answer.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else
            rdata_q <= req.rd ? rd_mux : 8'h00;
    end

    // Outputs. The interrupt is a plain level from registers: it stays high until software
    // reads the status register or masks the pending kinds, and it never pulses on its own.
    assign rdata        = rdata_q;
    assign scan_run_en  = !lp_en_q; // RULE14
    assign lp_scan_en   = lp_active;
    assign lp_electrode = lp_el_q; // RULE4
    assign lp_threshold = lp_thr_q; // RULE5
    assign lp_tick      = lp_active && (lp_cnt_q == '0);
    assign active_res   = res_act_q; // RULE7
    assign cap_event    = cap_ev_q;
    assign irq          = |(irq_st_q & irq_mask_q);

endmodule : ctle_event_cfg

// ==== ctle_event_cfg_checker.sv ====
// Purpose: Port assertions for the event and low-power configuration block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Enables are shadowed from host writes, since they are not ports.
`timescale 1ns/1ps
module ctle_event_cfg_checker
    import ctle_pkg::*;
(
    input wire logic        clk,          // Clock.
    input wire logic        rst_n,        // Reset, active low.
    input wire logic        in_shutdown,  // Shutdown mode.
    input wire ctle_sense_t sense,        // Measurement results.
    input wire ctle_req_t   req,          // Register request.
    input wire logic [7:0]  rdata,        // Read data.
    input wire logic        scan_run_en,  // Run scan allowed.
    input wire logic        lp_scan_en,   // Low-power scan active.
    input wire logic [1:0]  lp_electrode, // Shutdown electrode.
    input wire logic [6:0]  lp_threshold, // Low-power threshold.
    input wire logic        lp_tick,      // Scan pulse.
    input wire logic [3:0]  active_res,   // Resolution in use.
    input wire logic        cap_event,    // Event flag.
    input wire logic        irq           // Interrupt.
);
    logic [4:0] en_q;
    logic [3:0] prev_q;
    wire        touch_hit = sense.meas_done && sense.touched != 4'h0 && prev_q == 4'h0;
    wire        rel_hit   = sense.meas_done && sense.touched == 4'h0 && prev_q != 4'h0;
    wire        ev_rd     = req.rd && req.addr == OFS_EVENT_ENABLES;
    // The shadow resets to zero; the bench writes enables before any event.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            en_q   <= 5'h00;
            prev_q <= 4'h0;
        end
        else
        begin
            if (req.wr && req.addr == OFS_EVENT_ENABLES) en_q <= req.wdata[4:0];
            if (sense.meas_done) prev_q <= sense.touched;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    first_touch_a: assert property (touch_hit && en_q[0] |=> cap_event)
        else $error("touch did not raise the flag");
    all_release_a: assert property (rel_hit && en_q[4] |=> cap_event)
        else $error("release did not raise the flag");
    flag_sticky_a: assert property (cap_event && !ev_rd |=> cap_event)
        else $error("flag dropped without a read");
    flag_clear_a: assert property (ev_rd && !sense.meas_done |=> !cap_event)
        else $error("flag survived its read");
    no_spurious_a: assert property (!cap_event && !sense.meas_done |=> !cap_event)
        else $error("flag rose with no measurement");
    run_blocked_a: assert property (lp_scan_en |-> !scan_run_en)
        else $error("run scan allowed in low power");
    reset_run_a: assert property ($rose(rst_n) |-> scan_run_en && !lp_scan_en)
        else $error("low power enable survived reset");
    res_frozen_a: assert property ($past(rst_n) |-> $stable(active_res))
        else $error("resolution changed outside reset");
    elec_follow_a: assert property (req.wr && req.addr == OFS_ELECTRODE_SEL
        |=> lp_electrode == $past(req.wdata[1:0]))
        else $error("electrode select not applied");
    thresh_follow_a: assert property (req.wr && req.addr == OFS_LP_THRESHOLD
        |=> lp_threshold == $past(req.wdata[6:0]))
        else $error("threshold not applied");
    cover property (touch_hit && en_q[0]);
    cover property (rel_hit && en_q[4]);
    cover property (lp_tick);
endmodule : ctle_event_cfg_checker

bind ctle_event_cfg ctle_event_cfg_checker ctle_event_cfg_checker_i (.clk(clk), .rst_n(rst_n),
    .in_shutdown(in_shutdown), .sense(sense), .req(req), .rdata(rdata),
    .scan_run_en(scan_run_en), .lp_scan_en(lp_scan_en), .lp_electrode(lp_electrode),
    .lp_threshold(lp_threshold), .lp_tick(lp_tick), .active_res(active_res),
    .cap_event(cap_event), .irq(irq));

// ==== ctle_event_cfg_tb.sv ====
// Purpose: Directed bench for the event and low-power configuration block.
// Assumes: 40 MHz clock; scan period measured on code 0 only.
// Notes:   Longer scan codes would exceed the run budget.
`timescale 1ns/1ps
module ctle_event_cfg_tb
    import ctle_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, in_shutdown = 1'b0;
    ctle_sense_t sense = '0;
    ctle_req_t   req = '0;
    logic [7:0]  rdata;
    logic [6:0]  lp_threshold;
    logic [3:0]  active_res;
    logic [1:0]  lp_electrode;
    logic        scan_run_en, lp_scan_en, lp_tick, cap_event, irq;
    int          fail_count = 0, compares = 0, cycles = 0;
    always #12.5 clk = ~clk;
    ctle_event_cfg ctle_event_cfg_i (.clk(clk), .rst_n(rst_n), .in_shutdown(in_shutdown),
        .sense(sense), .req(req), .rdata(rdata), .scan_run_en(scan_run_en),
        .lp_scan_en(lp_scan_en), .lp_electrode(lp_electrode), .lp_threshold(lp_threshold),
        .lp_tick(lp_tick), .active_res(active_res), .cap_event(cap_event), .irq(irq));
    // The ceiling allows one scan period plus the short tests.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Each request ends with a cleared strobe, so calls leave a one-cycle gap.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1 chk(n, e, rdata);
    endtask : rd
    task automatic meas(input logic [3:0] t, input logic [3:0] p);
        @(posedge clk);
        sense <= '{meas_done: 1'b1, touched: t, position: p};
        @(posedge clk);
        sense <= '0;
        #1;
    endtask : meas
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task automatic t_regs;
        #1 chk("threshold rst", 8'h10, lp_threshold);
        chk("run rst", 1, scan_run_en);
        wr(OFS_ELECTRODE_SEL, 8'h03);
        chk("electrode", 2'h3, lp_electrode);
        wr(OFS_LP_THRESHOLD, 8'h7f);
        chk("threshold", 7'h7f, lp_threshold);
        rd(4'hf, 8'h00, "unmapped");
        for (int c = 0; c < 16; c++)
        begin
            wr(OFS_SCAN_INTERVAL, 8'(c));
            rd(OFS_SCAN_INTERVAL, 8'(c), "scan code");
        end
        $display("test regs done");
    endtask : t_regs
    // Only code 0 is timed; it is the shortest documented interval.
    task automatic t_lowpow;
        int n;
        wr(OFS_SCAN_INTERVAL, 8'h00);
        wr(OFS_SYS_CONFIG, 8'h04);
        chk("run off", 0, scan_run_en);
        chk("lp idle", 0, lp_scan_en);
        @(posedge clk) in_shutdown <= 1'b1;
        #1 chk("first tick", 1, lp_tick);
        n = 0;
        do
        begin
            @(posedge clk) #1 n++;
        end
        while (lp_tick !== 1'b1 && n < 50000);
        chk("tick period", CYC_PER_MS, n);
        chk("lp on", 1, lp_scan_en);
        wr(OFS_RESOLUTION, 8'h0a);
        wr(OFS_RESOLUTION, 8'h0c);
        chk("res held", 4'h8, active_res);
        rd(OFS_RESOLUTION, 8'h0a, "res rd");
        @(posedge clk) in_shutdown <= 1'b0;
        do_reset();
        #1 chk("res new", 4'ha, active_res);
        rd(OFS_SYS_CONFIG, 8'h00, "lp enable rst");
        $display("test lowpower done");
    endtask : t_lowpow
    task automatic t_touch;
        wr(OFS_CONTROL_TYPE, 8'h00);
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_EVENT_ENABLES, 8'h01);
        meas(4'h1, 4'h0);
        chk("touch flag", 1, cap_event);
        @(posedge clk) #1 chk("irq", 1, irq);
        rd(OFS_EVENT_ENABLES, 8'h81, "enables");
        chk("flag clear", 0, cap_event);
        rd(OFS_IRQ_STATUS, 8'h01, "status");
        @(posedge clk) #1 chk("irq off", 0, irq);
        meas(4'h0, 4'h0);
        chk("no release", 0, cap_event);
        wr(OFS_EVENT_ENABLES, 8'h10);
        meas(4'h2, 4'h0);
        chk("no touch", 0, cap_event);
        meas(4'h0, 4'h0);
        rd(OFS_EVENT_ENABLES, 8'h90, "release");
        chk("irq masked", 0, irq);
        wr(OFS_EVENT_ENABLES, 8'h02);
        meas(4'h1, 4'h3);
        meas(4'h1, 4'h5);
        chk("keypad move", 0, cap_event);
        for (int ct = 1; ct < 3; ct++)
        begin
            wr(OFS_CONTROL_TYPE, 8'(ct));
            meas(4'h1, 4'(ct + 5));
            rd(OFS_EVENT_ENABLES, 8'h82, "move");
        end
        meas(4'h0, 4'h0);
        $display("test touch done");
    endtask : t_touch
    task automatic t_repeat;
        int last, gap;
        logic any;
        wr(OFS_CONTROL_TYPE, 8'h00);
        wr(OFS_REPEAT_DELAY, 8'h00);
        wr(OFS_REPEAT_PERIOD, 8'h03);
        wr(OFS_EVENT_ENABLES, 8'h04);
        meas(4'h1, 4'h0);
        meas(4'h1, 4'h0);
        rd(OFS_EVENT_ENABLES, 8'h84, "hold");
        repeat (3) meas(4'h1, 4'h0);
        chk("hold once", 0, cap_event);
        wr(OFS_EVENT_ENABLES, 8'h08);
        last = -1;
        gap = 0;
        for (int i = 0; i < 10; i++)
        begin
            meas(4'h1, 4'h0);
            if (cap_event === 1'b1)
            begin
                if (last >= 0) gap = i - last;
                last = i;
                rd(OFS_EVENT_ENABLES, 8'h88, "repeat");
            end
        end
        chk("repeat gap", 3, gap);
        wr(OFS_REPEAT_PERIOD, 8'h00);
        any = 1'b0;
        repeat (6)
        begin
            meas(4'h1, 4'h0);
            any = any | cap_event;
        end
        chk("repeat off", 0, any);
        meas(4'h0, 4'h0);
        wr(OFS_REPEAT_DELAY, 8'h02);
        wr(OFS_EVENT_ENABLES, 8'h04);
        repeat (3) meas(4'h1, 4'h0);
        chk("hold early", 0, cap_event);
        meas(4'h1, 4'h0);
        rd(OFS_EVENT_ENABLES, 8'h84, "hold late");
        $display("test repeat done");
    endtask : t_repeat
    initial
    begin
        do_reset();
        wr(OFS_RESOLUTION, 8'h08);
        do_reset();
        t_regs();
        t_lowpow();
        t_touch();
        t_repeat();
        conclude();
    end
endmodule : ctle_event_cfg_tb
